// ### test/anlpx_regs_test.sv
// Self-checking bench for the partner next page and negotiated mode registers.
`timescale 1ns/10ps
`include "anlpx_defines.svh"

// Compare one expected value with one observed value and count the outcome.
`define ANLPX_CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end

module anlpx_regs_test;
    import anlpx_pkg::*;

    logic i_clock, i_sys_rst, i_page_valid, i_mgmt_rd, i_mgmt_wr;
    logic i_resolved_kr_fec, i_resolved_kr_10g, i_resolved_kx_1g;
    anlpx_page_t i_page_word;
    logic [4:0] i_mgmt_devad;
    logic [15:0] i_mgmt_addr;
    anlpx_word_t o_mgmt_rdata;
    logic o_mgmt_ack, o_mgmt_hit;
    int err_count = 0;
    int check_count = 0;
    int cycle_count = 0;

    anlpx_regs u_dut (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_page_valid(i_page_valid), .i_page_word(i_page_word),
        .i_resolved_kr_fec(i_resolved_kr_fec), .i_resolved_kr_10g(i_resolved_kr_10g),
        .i_resolved_kx_1g(i_resolved_kx_1g),
        .i_mgmt_rd(i_mgmt_rd), .i_mgmt_wr(i_mgmt_wr),
        .i_mgmt_devad(i_mgmt_devad), .i_mgmt_addr(i_mgmt_addr),
        .o_mgmt_rdata(o_mgmt_rdata), .o_mgmt_ack(o_mgmt_ack), .o_mgmt_hit(o_mgmt_hit)
    );

    // Free running 25 MHz clock.
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // The whole run needs about a hundred cycles, so a hang is cut well before it wastes time.
    always @(posedge i_clock) begin
        cycle_count++;
        if (cycle_count == 3000) begin
            err_count++;
            give_verdict();
        end
    end

    // Print the verdict and stop.
    task give_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One read pulse; the answer is registered, so it is looked at one cycle later.
    task automatic rd_reg(input logic [4:0] dv, input logic [15:0] a, output anlpx_word_t d);
        @(negedge i_clock);
        i_mgmt_rd = 1'b1;
        i_mgmt_devad = dv;
        i_mgmt_addr = a;
        @(negedge i_clock);
        i_mgmt_rd = 1'b0;
        d = o_mgmt_rdata;
        `ANLPX_CHK("read ack", 1'b1, o_mgmt_ack)
    endtask

    // Read and compare both the data and the hit flag.
    task automatic rd_chk(input logic [4:0] dv, input logic [15:0] a, input anlpx_word_t e,
                          input logic eh, input string nm);
        anlpx_word_t d;
        rd_reg(dv, a, d);
        `ANLPX_CHK(nm, e, d)
        `ANLPX_CHK("read hit", eh, o_mgmt_hit)
    endtask

    // One write pulse; no write data exists, only the acknowledge and hit come back.
    task automatic wr_chk(input logic [4:0] dv, input logic [15:0] a, input logic eh);
        @(negedge i_clock);
        i_mgmt_wr = 1'b1;
        i_mgmt_devad = dv;
        i_mgmt_addr = a;
        @(negedge i_clock);
        i_mgmt_wr = 1'b0;
        `ANLPX_CHK("write ack", 1'b1, o_mgmt_ack)
        `ANLPX_CHK("write hit", eh, o_mgmt_hit)
    endtask

    // Hand one received page to the block as a single-cycle strobe.
    task automatic load_page(input anlpx_page_t w);
        @(negedge i_clock);
        i_page_valid = 1'b1;
        i_page_word = w;
        @(negedge i_clock);
        i_page_valid = 1'b0;
    endtask

    // Values straight after reset, plus unmapped places.
    task test_reset();
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_MID, 16'h0000, 1'b1, "mid reset");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_HIGH, 16'h0000, 1'b1, "high reset");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_LOW, 16'h0000, 1'b1, "low reset");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_STATUS, 16'h0001, 1'b1, "status reset");
        rd_chk(`ANLPX_DEVAD, 16'h0020, 16'h0000, 1'b0, "unmapped");
        rd_chk(5'h01, `ANLPX_OFF_STATUS, 16'h0000, 1'b0, "other device");
    endtask

    // Two pages with opposite flag patterns, checked field by field.
    task test_fields();
        anlpx_page_t w;
        anlpx_word_t d;
        for (int k = 0; k < 2; k++) begin
            w = (k == 0) ? 48'h1234_9ABC_A9F3 : 48'hEDCB_6543_5608;
            load_page(w);
            rd_reg(`ANLPX_DEVAD, `ANLPX_OFF_LOW, d);
            `ANLPX_CHK("more pages", w[15], d[15])
            `ANLPX_CHK("page ack", w[14], d[14])
            `ANLPX_CHK("message page", w[13], d[13])
            `ANLPX_CHK("can comply", w[12], d[12])
            `ANLPX_CHK("toggle", w[11], d[11])
            `ANLPX_CHK("code field", w[10:0], d[10:0])
            rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_MID, w[31:16], 1'b1, "mid bits");
            rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_HIGH, w[47:32], 1'b1, "high bits");
        end
    endtask

    // A new page between the low read and the upper reads must not tear the view.
    task test_coherent();
        load_page(48'h1111_2222_3333);
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_LOW, 16'h3333, 1'b1, "low first");
        load_page(48'h4444_5555_6666);
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_MID, 16'h2222, 1'b1, "held mid");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_HIGH, 16'h1111, 1'b1, "held high");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_LOW, 16'h6666, 1'b1, "low second");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_MID, 16'h5555, 1'b1, "new mid");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_HIGH, 16'h4444, 1'b1, "new high");
    endtask

    // Every combination of resolved modes; inputs settle one cycle before the read.
    task test_status();
        anlpx_word_t e;
        for (int k = 0; k < 8; k++) begin
            @(negedge i_clock);
            i_resolved_kr_fec = k[2];
            i_resolved_kr_10g = k[1];
            i_resolved_kx_1g = k[0];
            e = {11'h000, k[2], k[1], 1'b0, k[0], 1'b1};
            rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_STATUS, e, 1'b1, "status");
        end
    endtask

    // Writes are acknowledged but change nothing.
    task test_write();
        wr_chk(`ANLPX_DEVAD, `ANLPX_OFF_LOW, 1'b1);
        wr_chk(`ANLPX_DEVAD, `ANLPX_OFF_STATUS, 1'b1);
        wr_chk(`ANLPX_DEVAD, 16'h0031, 1'b0);
        wr_chk(5'h03, `ANLPX_OFF_LOW, 1'b0);
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_STATUS, 16'h001B, 1'b1, "status kept");
        rd_chk(`ANLPX_DEVAD, `ANLPX_OFF_LOW, 16'h6666, 1'b1, "low kept");
    endtask

    // Page, low read, new page and upper read on consecutive cycles; this tight
    // timing lands a page between the low read and the upper read with no idle cycle.
    task test_back_to_back();
        @(negedge i_clock);
        i_page_valid = 1'b1;
        i_page_word = 48'hA1A2_B1B2_C1C2;
        @(negedge i_clock);
        i_page_valid = 1'b0;
        i_mgmt_rd = 1'b1;
        i_mgmt_devad = `ANLPX_DEVAD;
        i_mgmt_addr = `ANLPX_OFF_LOW;
        @(negedge i_clock);
        `ANLPX_CHK("tight low", 16'hC1C2, o_mgmt_rdata)
        i_mgmt_rd = 1'b0;
        i_page_valid = 1'b1;
        i_page_word = 48'hD1D2_E1E2_F1F2;
        @(negedge i_clock);
        i_page_valid = 1'b0;
        i_mgmt_rd = 1'b1;
        i_mgmt_addr = `ANLPX_OFF_MID;
        @(negedge i_clock);
        `ANLPX_CHK("tight held mid", 16'hB1B2, o_mgmt_rdata)
        i_mgmt_addr = `ANLPX_OFF_LOW;
        @(negedge i_clock);
        `ANLPX_CHK("tight low two", 16'hF1F2, o_mgmt_rdata)
        i_mgmt_rd = 1'b0;
        i_page_valid = 1'b1;
        i_page_word = 48'h0102_0304_0506;
        @(negedge i_clock);
        i_page_valid = 1'b0;
        i_mgmt_rd = 1'b1;
        i_mgmt_addr = `ANLPX_OFF_HIGH;
        @(negedge i_clock);
        `ANLPX_CHK("tight held high", 16'hD1D2, o_mgmt_rdata)
        i_mgmt_rd = 1'b0;
    endtask

    // Main sequence: all inputs defined at time zero, reset for 16 cycles.
    initial begin
        i_sys_rst = 1'b1;
        i_page_valid = 1'b0;
        i_page_word = 48'h0000_0000_0000;
        i_resolved_kr_fec = 1'b0;
        i_resolved_kr_10g = 1'b0;
        i_resolved_kx_1g = 1'b0;
        i_mgmt_rd = 1'b0;
        i_mgmt_wr = 1'b0;
        i_mgmt_devad = 5'h00;
        i_mgmt_addr = 16'h0000;
        repeat (16) @(negedge i_clock);
        i_sys_rst = 1'b0;
        test_reset();
        test_fields();
        test_coherent();
        test_status();
        test_write();
        test_back_to_back();
        give_verdict();
    end
endmodule

// ### verilog/anlpx_defines.svh
// Offsets, field positions, reset values and decode constants of the partner next page registers.
`ifndef ANLPX_DEFINES_SVH
`define ANLPX_DEFINES_SVH

// Management device address that holds the negotiation registers.
`define ANLPX_DEVAD 5'h07

// Register offsets inside the management device.
`define ANLPX_OFF_LOW 16'h0019
`define ANLPX_OFF_MID 16'h001A
`define ANLPX_OFF_HIGH 16'h001B
`define ANLPX_OFF_STATUS 16'h0030

// Field positions of the first received next page register.
`define ANLPX_BIT_MORE_PAGES 15
`define ANLPX_BIT_PAGE_ACK 14
`define ANLPX_BIT_MESSAGE_PAGE 13
`define ANLPX_BIT_CAN_COMPLY 12
`define ANLPX_BIT_TOGGLE 11
`define ANLPX_CODE_MSB 10
`define ANLPX_CODE_LSB 0

// Slices of the 48-bit partner code word held by the second and third registers.
`define ANLPX_MID_MSB 31
`define ANLPX_MID_LSB 16
`define ANLPX_HIGH_MSB 47
`define ANLPX_HIGH_LSB 32

// Field positions of the negotiation status register.
`define ANLPX_BIT_KR_FEC 4
`define ANLPX_BIT_KR_10G 3
`define ANLPX_BIT_KX_1G 1
`define ANLPX_BIT_PRESENT 0

// Reset values.
`define ANLPX_RST_PAGE 48'h0000_0000_0000
`define ANLPX_RST_WORD 16'h0000
`define ANLPX_RST_STATUS 16'h0001

`endif

// ### verilog/anlpx_hold.sv
// Storage of the last received partner page and of its held upper half.
`timescale 1ns/10ps
`include "anlpx_defines.svh"

module anlpx_hold (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Page arriving from the negotiation receiver
    input wire logic i_load,
    input wire anlpx_pkg::anlpx_page_t i_page,
    // Capture strobe from a read of the first register
    input wire logic i_snap,
    // Stored values
    output anlpx_pkg::anlpx_page_t o_live,
    output anlpx_pkg::anlpx_upper_t o_snap
);
    import anlpx_pkg::*;

    // The live page follows every page the receiver hands over.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_live <= `ANLPX_RST_PAGE;
        end else if (i_load) begin
            o_live <= i_page;
        end
    end

    // Each 16-bit upper word is held separately; the capture takes the page
    // before any load in the same cycle, so a read never mixes two pages.
    genvar w;
    generate
        for (w = 0; w < 2; w = w + 1) begin : g_word
            always_ff @(posedge i_clock) begin
                if (i_sys_rst) begin
                    o_snap[w*16 +: 16] <= `ANLPX_RST_WORD;
                end else if (i_snap) begin
                    o_snap[w*16 +: 16] <= o_live[16 + w*16 +: 16];
                end
            end
        end
    endgenerate

endmodule

// ### verilog/anlpx_pkg.sv
// Types shared by the partner next page register files.
package anlpx_pkg;

    // One management register word.
    typedef logic [15:0] anlpx_word_t;

    // A whole received next page code word.
    typedef logic [47:0] anlpx_page_t;

    // Upper 32 bits of a page, as held for a coherent read.
    typedef logic [31:0] anlpx_upper_t;

    // Whether the upper registers show the live page or the held copy.
    typedef enum logic {
        SNAP_LIVE,
        SNAP_HELD
    } anlpx_snap_t;

endpackage

// ### verilog/anlpx_regs.sv
// Partner next page and negotiated mode registers on the management port.
`timescale 1ns/10ps
`include "anlpx_defines.svh"

module anlpx_regs (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Negotiation receiver: page strobe with its word, and resolved modes
    input wire logic i_page_valid,
    input wire anlpx_pkg::anlpx_page_t i_page_word,
    input wire logic i_resolved_kr_fec,
    input wire logic i_resolved_kr_10g,
    input wire logic i_resolved_kx_1g,
    // Management register port
    input wire logic i_mgmt_rd,
    input wire logic i_mgmt_wr,
    input wire logic [4:0] i_mgmt_devad,
    input wire logic [15:0] i_mgmt_addr,
    output anlpx_pkg::anlpx_word_t o_mgmt_rdata,
    output logic o_mgmt_ack,
    output logic o_mgmt_hit
);
    import anlpx_pkg::*;

    // True when the access names one register of this group.
    function automatic logic addr_is(input logic [4:0] devad, input logic [15:0] addr,
                                     input logic [15:0] off);
        addr_is = (devad == `ANLPX_DEVAD) && (addr == off);
    endfunction

    anlpx_page_t live_page;
    anlpx_upper_t snap_upper;
    anlpx_snap_t snap_state;
    anlpx_snap_t next_snap_state;
    logic kr_fec;
    logic kr_10g;
    logic kx_1g;
    logic hit_low;
    logic hit_mid;
    logic hit_high;
    logic hit_status;
    logic hit_any;
    logic rd_low;
    logic rd_mid;
    logic rd_high;
    logic rd_status;
    anlpx_word_t low_word;
    anlpx_word_t mid_word;
    anlpx_word_t high_word;
    anlpx_word_t status_word;
    anlpx_word_t next_rdata;

    // Address decode; only device 0x07 at the four offsets answers with data.
    assign hit_low = addr_is(i_mgmt_devad, i_mgmt_addr, `ANLPX_OFF_LOW);
    assign hit_mid = addr_is(i_mgmt_devad, i_mgmt_addr, `ANLPX_OFF_MID);
    assign hit_high = addr_is(i_mgmt_devad, i_mgmt_addr, `ANLPX_OFF_HIGH);
    assign hit_status = addr_is(i_mgmt_devad, i_mgmt_addr, `ANLPX_OFF_STATUS);
    assign hit_any = hit_low | hit_mid | hit_high | hit_status;
    assign rd_low = i_mgmt_rd & hit_low;
    assign rd_mid = i_mgmt_rd & hit_mid;
    assign rd_high = i_mgmt_rd & hit_high;
    assign rd_status = i_mgmt_rd & hit_status;

    // Page storage; a read of the first register freezes the upper half.
    anlpx_hold u_hold (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_load(i_page_valid),
        .i_page(i_page_word),
        .i_snap(rd_low),
        .o_live(live_page),
        .o_snap(snap_upper)
    );

    // Until the first register has been read once, the upper registers show
    // the live page; afterwards they show the copy taken by the last such read.
    always_comb begin
        next_snap_state = snap_state;
        case (snap_state)
            SNAP_LIVE: begin
                if (rd_low) begin
                    next_snap_state = SNAP_HELD;
                end
            end
            SNAP_HELD: begin
                next_snap_state = SNAP_HELD;
            end
            default: begin
                next_snap_state = SNAP_LIVE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            snap_state <= SNAP_LIVE;
        end else begin
            snap_state <= next_snap_state;
        end
    end

    // Resolved modes come from the receiver on this clock and are simply
    // registered; they are levels, so no event can be lost here.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            kr_fec <= 1'b0;
            kr_10g <= 1'b0;
            kx_1g <= 1'b0;
        end else begin
            kr_fec <= i_resolved_kr_fec;
            kr_10g <= i_resolved_kr_10g;
            kx_1g <= i_resolved_kx_1g;
        end
    end

    // First register: the low 16 bits of the live page, field by field.
    assign low_word[`ANLPX_BIT_MORE_PAGES] = live_page[`ANLPX_BIT_MORE_PAGES];
    assign low_word[`ANLPX_BIT_PAGE_ACK] = live_page[`ANLPX_BIT_PAGE_ACK];
    assign low_word[`ANLPX_BIT_MESSAGE_PAGE] = live_page[`ANLPX_BIT_MESSAGE_PAGE];
    assign low_word[`ANLPX_BIT_CAN_COMPLY] = live_page[`ANLPX_BIT_CAN_COMPLY];
    assign low_word[`ANLPX_BIT_TOGGLE] = live_page[`ANLPX_BIT_TOGGLE];
    assign low_word[`ANLPX_CODE_MSB:`ANLPX_CODE_LSB] =
        live_page[`ANLPX_CODE_MSB:`ANLPX_CODE_LSB];

    // Upper registers; software that skips the first read gets no coherence.
    assign mid_word = (snap_state == SNAP_HELD) ? snap_upper[15:0]
                    : live_page[`ANLPX_MID_MSB:`ANLPX_MID_LSB];
    assign high_word = (snap_state == SNAP_HELD) ? snap_upper[31:16]
                     : live_page[`ANLPX_HIGH_MSB:`ANLPX_HIGH_LSB];

    // Status word; reserved bits read zero and the ability bit is tied high.
    assign status_word[15:5] = 11'h000;
    assign status_word[`ANLPX_BIT_KR_FEC] = kr_fec;
    assign status_word[`ANLPX_BIT_KR_10G] = kr_10g;
    assign status_word[2] = 1'b0;
    assign status_word[`ANLPX_BIT_KX_1G] = kx_1g;
    assign status_word[`ANLPX_BIT_PRESENT] = 1'b1;

    // Read data select; an unmapped address answers with zero.
    assign next_rdata = hit_low ? low_word
                      : hit_mid ? mid_word
                      : hit_high ? high_word
                      : hit_status ? status_word
                      : `ANLPX_RST_WORD;

    // Every access is acknowledged one cycle later; writes change nothing
    // because the whole group is read-only.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_mgmt_rdata <= `ANLPX_RST_WORD;
            o_mgmt_ack <= 1'b0;
            o_mgmt_hit <= 1'b0;
        end else begin
            o_mgmt_ack <= i_mgmt_rd | i_mgmt_wr;
            o_mgmt_hit <= (i_mgmt_rd | i_mgmt_wr) & hit_any;
            if (i_mgmt_rd) begin
                o_mgmt_rdata <= next_rdata;
            end
        end
    end

    // Checks on the register behaviour.
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    // A page arrives, then the first register is read without a new page.
    sequence s_page_then_low;
        (i_page_valid ##1 (rd_low && !i_page_valid));
    endsequence

    // First register read, a new page lands, then a middle register read.
    sequence s_low_newpage_mid;
        (rd_low ##1 (i_page_valid && !rd_low) ##1 (rd_mid && !rd_low));
    endsequence

    sequence s_low_newpage_high;
        (rd_low ##1 (i_page_valid && !rd_low) ##1 (rd_high && !rd_low));
    endsequence

    // Every access is answered on the next cycle and never without one.
    a_ack_one_cycle: assert property ((i_mgmt_rd || i_mgmt_wr) |=> o_mgmt_ack)
        else $error("access not acknowledged on the next cycle");

    a_no_idle_ack: assert property (!(i_mgmt_rd || i_mgmt_wr) |=> !o_mgmt_ack)
        else $error("acknowledge without an access");

    // The hit flag only qualifies an acknowledge; a stray hit would mislead
    // software that probes the map for holes.
    a_hit_with_ack: assert property (o_mgmt_hit |-> o_mgmt_ack)
        else $error("hit flag raised without an acknowledge");

    a_mapped_hit: assert property (((i_mgmt_rd || i_mgmt_wr) && hit_any)
        |=> o_mgmt_hit)
        else $error("mapped access did not report a hit");

    // Read data stands until the next read, so a slow master may take it late.
    a_rdata_stands: assert property (!i_mgmt_rd |=> $stable(o_mgmt_rdata))
        else $error("read data changed without a read");

    // The stored page follows the strobe and nothing else.
    a_page_stored: assert property (i_page_valid
        |=> live_page == $past(i_page_word))
        else $error("received page not stored on its strobe");

    a_page_kept: assert property (!i_page_valid |=> $stable(live_page))
        else $error("stored page changed without a strobe");

    // The first register always shows the live page, never the held copy.
    a_low_read_live: assert property (rd_low
        |=> o_mgmt_rdata == $past(live_page[15:0]))
        else $error("first register does not show the stored page");

    a_low_fields_page: assert property (s_page_then_low
        |=> o_mgmt_rdata == $past(i_page_word[15:0], 2))
        else $error("first register does not show the received page low bits");

    // Capture and hold of the upper half around a read of the first register.
    a_snap_capture: assert property (rd_low
        |=> snap_upper == $past(live_page[47:16]))
        else $error("read of the first register did not capture the upper half");

    a_snap_kept: assert property (!rd_low |=> $stable(snap_upper))
        else $error("held upper half changed without a read of the first register");

    a_snap_sticky: assert property ((snap_state == SNAP_HELD)
        |=> (snap_state == SNAP_HELD))
        else $error("upper registers fell back to the live page");

    // Before the first read of the first register the upper words are live.
    a_mid_live_read: assert property ((rd_mid && (snap_state == SNAP_LIVE))
        |=> o_mgmt_rdata == $past(live_page[31:16]))
        else $error("middle register does not show the live page");

    a_high_live_read: assert property ((rd_high && (snap_state == SNAP_LIVE))
        |=> o_mgmt_rdata == $past(live_page[47:32]))
        else $error("high register does not show the live page");

    // Afterwards they show the copy taken by the latest read of the first register.
    a_held_mid_read: assert property ((rd_mid && (snap_state == SNAP_HELD))
        |=> o_mgmt_rdata == $past(snap_upper[15:0]))
        else $error("middle register does not show the held copy");

    a_held_high_read: assert property ((rd_high && (snap_state == SNAP_HELD))
        |=> o_mgmt_rdata == $past(snap_upper[31:16]))
        else $error("high register does not show the held copy");

    a_mid_coherent_read: assert property (s_low_newpage_mid
        |=> o_mgmt_rdata == $past(live_page[31:16], 3))
        else $error("middle register does not show the page held by the first read");

    a_high_coherent_read: assert property (s_low_newpage_high
        |=> o_mgmt_rdata == $past(live_page[47:32], 3))
        else $error("high register does not show the page held by the first read");

    a_reset_pages_zero: assert property ($past(i_sys_rst)
        |-> (live_page == `ANLPX_RST_PAGE) && (snap_state == SNAP_LIVE))
        else $error("page registers not zero after reset");

    // The status word is rebuilt from the registered modes on every read.
    a_status_fixed_bits: assert property (rd_status
        |=> o_mgmt_rdata[0] && !o_mgmt_rdata[2] && (o_mgmt_rdata[15:5] == 11'h000))
        else $error("status constant or reserved bits wrong");

    a_status_kr_fec: assert property (rd_status
        |=> o_mgmt_rdata[4] == $past(i_resolved_kr_fec, 2))
        else $error("status FEC bit does not follow the resolved mode");

    a_status_kr_kx: assert property (rd_status
        |=> (o_mgmt_rdata[3] == $past(i_resolved_kr_10g, 2))
            && (o_mgmt_rdata[1] == $past(i_resolved_kx_1g, 2)))
        else $error("status mode bits do not follow the resolved mode");

    a_status_kx_1g: assert property (rd_status
        |=> o_mgmt_rdata[1] == $past(i_resolved_kx_1g, 2))
        else $error("status 1G bit does not follow the resolved mode");

    // Writes leave every register as it was, and reads of holes in the map answer zero.
    a_write_no_effect: assert property ((i_mgmt_wr && !i_mgmt_rd && !i_page_valid)
        |=> $stable(live_page) && $stable(o_mgmt_rdata))
        else $error("a write changed a read-only register");

    a_unmapped_zero: assert property ((i_mgmt_rd && !hit_any)
        |=> (o_mgmt_rdata == `ANLPX_RST_WORD) && !o_mgmt_hit)
        else $error("unmapped read did not answer zero");

endmodule
